/* common/feedback_loop_pkg.sv */
package feedback_loop_pkg;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] FEEDBACK_LOOP_CONFIG_ADDR = 8'h23;
    localparam logic [7:0] FEEDBACK_LOOP_CONFIG_RESET = 8'h36;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ----------------------------------------
    // field layout
    // ----------------------------------------
    typedef struct packed {
        logic noiseGateLevel;
        logic [2:0] brakeFeedbackRatio;
        logic [1:0] loopGain;
        logic [1:0] backEmfAmpGain;
    } fbConfig_type;

    localparam logic [2:0] BRAKE_RATIO_OFF = 3'h7;

    // ----------------------------------------
    // brake to drive feedback ratios
    // ----------------------------------------
    localparam logic [4:0] BRAKE_RATIO_X1 = 5'h01;
    localparam logic [4:0] BRAKE_RATIO_X2 = 5'h02;
    localparam logic [4:0] BRAKE_RATIO_X3 = 5'h03;
    localparam logic [4:0] BRAKE_RATIO_X4 = 5'h04;
    localparam logic [4:0] BRAKE_RATIO_X6 = 5'h06;
    localparam logic [4:0] BRAKE_RATIO_X8 = 5'h08;
    localparam logic [4:0] BRAKE_RATIO_X16 = 5'h10;
    localparam logic [4:0] BRAKE_RATIO_NONE = 5'h00;

    // ----------------------------------------
    // noise gate thresholds, percent of supply
    // ----------------------------------------
    localparam int unsigned GATE_PCT_LOW = 4;
    localparam int unsigned GATE_PCT_HIGH = 8;
    localparam int unsigned PCT_SCALE = 100;

    // ----------------------------------------
    // back-emf gain in hundredths
    // ----------------------------------------
    localparam logic [11:0] LRA_GAIN_0 = 12'h1f4;
    localparam logic [11:0] LRA_GAIN_1 = 12'h3e8;
    localparam logic [11:0] LRA_GAIN_2 = 12'h7d0;
    localparam logic [11:0] LRA_GAIN_3 = 12'hbb8;
    localparam logic [11:0] ERM_GAIN_0 = 12'h022;
    localparam logic [11:0] ERM_GAIN_1 = 12'h069;
    localparam logic [11:0] ERM_GAIN_2 = 12'h0b6;
    localparam logic [11:0] ERM_GAIN_3 = 12'h190;

    // ----------------------------------------
    // decoded controls toward the loop
    // ----------------------------------------
    typedef struct packed {
        logic [4:0] brakeRatio;
        logic brakeFbEnable;
        logic [1:0] loopGain;
        logic [1:0] backEmfAmpGain;
        logic [11:0] ampGainX100;
    } loopCtrl_type;

endpackage

/* src/feedback_loop_control_reg.sv */
// Operation
// - drive below gate threshold outputs zero
// - gate bit: 0 is 4%, 1 is 8%
// - brake codes 0-6 give ratios 1,2,3,4,6,8,16
// - brake code 7 removes braking feedback
// - loop gain sets settling speed, resets 1
// - back-emf gain codes per LRA/ERM mode
// - calibration writes back-emf gain; software overrides
`timescale 1ns/1ps
`default_nettype none
module feedback_loop_control_reg
    import feedback_loop_pkg::*;
#(
    parameter int unsigned MAG_WIDTH = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // register access from the serial control engine
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    // calibration result
    input wire logic calGainWrEn,
    input wire logic [1:0] calGainValue,
    // actuator mode, high for LRA
    input wire logic lraMode,
    // drive path
    input wire logic [MAG_WIDTH-1:0] driveMag,
    output logic [MAG_WIDTH-1:0] gatedMag,
    // decoded controls
    output loopCtrl_type loopCtrl
);

    // ----------------------------------------
    // constants
    // ----------------------------------------
    localparam int unsigned FULL_SCALE = (1 << MAG_WIDTH) - 1;
    localparam int unsigned LOW_LIMIT = GATE_PCT_LOW * FULL_SCALE;
    localparam int unsigned HIGH_LIMIT = GATE_PCT_HIGH * FULL_SCALE;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    logic cfgSelect;
    logic cfgWrite;
    logic calWrite;

    always_comb begin
        cfgSelect = (regAddr == FEEDBACK_LOOP_CONFIG_ADDR);
        cfgWrite = regWrEn && cfgSelect;
        calWrite = calGainWrEn && !cfgWrite;
    end

    // ----------------------------------------
    // configuration register
    // ----------------------------------------
    fbConfig_type cfg_ff;
    fbConfig_type nxt_cfg;

    always_comb begin
        nxt_cfg = cfg_ff;
        if (cfgWrite) begin
            nxt_cfg = fbConfig_type'(regWrData);
        end else if (calWrite) begin
            nxt_cfg.backEmfAmpGain = calGainValue;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_ff <= fbConfig_type'(FEEDBACK_LOOP_CONFIG_RESET);
        end else begin
            cfg_ff <= nxt_cfg;
        end
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    logic [7:0] rdData_ff;
    logic [7:0] nxt_rdData;

    always_comb begin
        if (cfgSelect) begin
            nxt_rdData = 8'(cfg_ff);
        end else begin
            nxt_rdData = READ_UNMAPPED;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rdData_ff <= READ_UNMAPPED;
        end else begin
            rdData_ff <= nxt_rdData;
        end
    end

    assign regRdData = rdData_ff;

    // ----------------------------------------
    // noise gate threshold
    // ----------------------------------------
    logic [31:0] scaledMag;
    logic [31:0] gateLimit;
    logic gateOpen;

    always_comb begin
        scaledMag = 32'(driveMag) * 32'(PCT_SCALE);
        gateLimit = cfg_ff.noiseGateLevel ? 32'(HIGH_LIMIT) : 32'(LOW_LIMIT);
        gateOpen = (scaledMag >= gateLimit);
    end

    // ----------------------------------------
    // gated drive output
    // ----------------------------------------
    logic [MAG_WIDTH-1:0] gated_ff;
    logic [MAG_WIDTH-1:0] nxt_gated;

    always_comb begin
        nxt_gated = gateOpen ? driveMag : '0;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            gated_ff <= '0;
        end else begin
            gated_ff <= nxt_gated;
        end
    end

    assign gatedMag = gated_ff;

    // ----------------------------------------
    // brake ratio decode
    // ----------------------------------------
    logic [4:0] brakeRatioDec;
    logic brakeEnableDec;

    always_comb begin
        case (cfg_ff.brakeFeedbackRatio)
            3'h0: begin
                brakeRatioDec = BRAKE_RATIO_X1;
                brakeEnableDec = 1'b1;
            end
            3'h1: begin
                brakeRatioDec = BRAKE_RATIO_X2;
                brakeEnableDec = 1'b1;
            end
            3'h2: begin
                brakeRatioDec = BRAKE_RATIO_X3;
                brakeEnableDec = 1'b1;
            end
            3'h3: begin
                brakeRatioDec = BRAKE_RATIO_X4;
                brakeEnableDec = 1'b1;
            end
            3'h4: begin
                brakeRatioDec = BRAKE_RATIO_X6;
                brakeEnableDec = 1'b1;
            end
            3'h5: begin
                brakeRatioDec = BRAKE_RATIO_X8;
                brakeEnableDec = 1'b1;
            end
            3'h6: begin
                brakeRatioDec = BRAKE_RATIO_X16;
                brakeEnableDec = 1'b1;
            end
            BRAKE_RATIO_OFF: begin
                brakeRatioDec = BRAKE_RATIO_NONE;
                brakeEnableDec = 1'b0;
            end
            default: begin
                brakeRatioDec = BRAKE_RATIO_NONE;
                brakeEnableDec = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // back-emf gain decode
    // ----------------------------------------
    logic [11:0] lraGainDec;
    logic [11:0] ermGainDec;
    logic [11:0] ampGainDec;

    always_comb begin
        case (cfg_ff.backEmfAmpGain)
            2'h0: begin
                lraGainDec = LRA_GAIN_0;
                ermGainDec = ERM_GAIN_0;
            end
            2'h1: begin
                lraGainDec = LRA_GAIN_1;
                ermGainDec = ERM_GAIN_1;
            end
            2'h2: begin
                lraGainDec = LRA_GAIN_2;
                ermGainDec = ERM_GAIN_2;
            end
            default: begin
                lraGainDec = LRA_GAIN_3;
                ermGainDec = ERM_GAIN_3;
            end
        endcase
        ampGainDec = lraMode ? lraGainDec : ermGainDec;
    end

    // ----------------------------------------
    // loop control register
    // ----------------------------------------
    loopCtrl_type ctrl_ff;
    loopCtrl_type nxt_ctrl;

    always_comb begin
        nxt_ctrl.brakeRatio = brakeRatioDec;
        nxt_ctrl.brakeFbEnable = brakeEnableDec;
        nxt_ctrl.loopGain = cfg_ff.loopGain;
        nxt_ctrl.backEmfAmpGain = cfg_ff.backEmfAmpGain;
        nxt_ctrl.ampGainX100 = ampGainDec;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_ff <= '0;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    assign loopCtrl = ctrl_ff;

endmodule // feedback_loop_control_reg
`default_nettype wire

/* tb/feedback_loop_control_reg_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module feedback_loop_control_reg_asserts
    import feedback_loop_pkg::*;
#(parameter int unsigned MAG_WIDTH = 8) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // watched ports
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    input wire logic calGainWrEn,
    input wire logic [1:0] calGainValue,
    input wire logic lraMode,
    input wire logic [MAG_WIDTH-1:0] driveMag,
    input wire logic [MAG_WIDTH-1:0] gatedMag,
    input wire loopCtrl_type loopCtrl
);
    localparam int FS = 2**MAG_WIDTH-1;
    localparam logic [4:0] RATIO [8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h10, 5'h00};
    localparam logic [11:0] AMP [8] = '{12'h022, 12'h069, 12'h0b6, 12'h190, 12'h1f4, 12'h3e8, 12'h7d0, 12'hbb8};
    wire logic wrCfg = regWrEn && regAddr == FEEDBACK_LOOP_CONFIG_ADDR;
    logic gateBit_ff;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            gateBit_ff <= FEEDBACK_LOOP_CONFIG_RESET[7];
        end else if (wrCfg) begin
            gateBit_ff <= regWrData[7];
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    a_gate_zero: assert property (driveMag*100 < 4*FS |=> gatedMag == 0) else $error("gate low");
    a_gate_pass: assert property (driveMag*100 >= 8*FS |=> gatedMag == $past(driveMag)) else $error("gate");
    a_gate_mid_pass: assert property (driveMag*100 >= 4*FS && driveMag*100 < 8*FS && !gateBit_ff
        |=> gatedMag == $past(driveMag)) else $error("gate mid pass");
    a_gate_mid_zero: assert property (driveMag*100 >= 4*FS && driveMag*100 < 8*FS && gateBit_ff
        |=> gatedMag == 0) else $error("gate mid zero");
    a_brake_ratio: assert property (wrCfg |-> ##2 loopCtrl.brakeRatio == RATIO[$past(regWrData[6:4], 2)])
        else $error("ratio");
    a_brake_off: assert property (wrCfg && regWrData[6:4] == 3'h7 |-> ##2 !loopCtrl.brakeFbEnable)
        else $error("brk");
    a_loop_gain: assert property (wrCfg |-> ##2 loopCtrl.loopGain == $past(regWrData[3:2], 2))
        else $error("loop");
    a_amp_table: assert property ($past(rst_b)
        |-> loopCtrl.ampGainX100 == AMP[{$past(lraMode), loopCtrl.backEmfAmpGain}]) else $error("amp");
    a_cal_gain: assert property (calGainWrEn && !wrCfg ##1 !wrCfg && !calGainWrEn
        |=> loopCtrl.backEmfAmpGain == $past(calGainValue, 2)) else $error("cal");
    a_read_back: assert property (wrCfg ##1 regAddr == FEEDBACK_LOOP_CONFIG_ADDR
        |=> regRdData == $past(regWrData, 2)) else $error("rd");
endmodule // feedback_loop_control_reg_asserts
bind feedback_loop_control_reg feedback_loop_control_reg_asserts #(.MAG_WIDTH(MAG_WIDTH)) chk_u (
    .mclk(mclk),
    .rst_b(rst_b),
    .regAddr(regAddr),
    .regWrEn(regWrEn),
    .regWrData(regWrData),
    .regRdData(regRdData),
    .calGainWrEn(calGainWrEn),
    .calGainValue(calGainValue),
    .lraMode(lraMode),
    .driveMag(driveMag),
    .gatedMag(gatedMag),
    .loopCtrl(loopCtrl)
);
`default_nettype wire

/* tb/feedback_loop_control_reg_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module feedback_loop_control_reg_tb_top
    import feedback_loop_pkg::*;
;
    logic mclk = 1'b0, rst_b = 1'b0, regWrEn = 1'b0, calGainWrEn = 1'b0, lraMode = 1'b0;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, driveMag = 8'h00, regRdData, gatedMag;
    logic [1:0] calGainValue = 2'h0;
    loopCtrl_type loopCtrl;
    int miscompares = 0, comparisons = 0;
    logic [7:0] gateExp;
    logic [4:0] ratio [8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h10, 5'h00};
    logic [11:0] amp [8] = '{12'h022, 12'h069, 12'h0b6, 12'h190, 12'h1f4, 12'h3e8, 12'h7d0, 12'hbb8};
    logic [7:0] mags [8] = '{8'h0a, 8'h0b, 8'h0b, 8'h15, 8'h14, 8'h14, 8'h0a, 8'hff};
    feedback_loop_control_reg dut_u (.mclk(mclk), .rst_b(rst_b), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdData(regRdData), .calGainWrEn(calGainWrEn), .calGainValue(calGainValue),
        .lraMode(lraMode), .driveMag(driveMag), .gatedMag(gatedMag), .loopCtrl(loopCtrl));
    initial begin
        forever #4 mclk = ~mclk;
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk) {regAddr, regWrData, regWrEn} <= {a, d, 1'b1};
        @(posedge mclk) regWrEn <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk) regAddr <= a;
        repeat (2) @(posedge mclk);
        #1 chk("regRdData", e, regRdData);
    endtask
    task end_of_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #20000 miscompares++;
        end_of_test;
    end
    initial begin
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        rd(8'h23, 8'h36);
        chk("brakeRatio", 4, loopCtrl.brakeRatio);
        chk("loopGain", 1, loopCtrl.loopGain);
        chk("ampGainX100", 12'h0b6, loopCtrl.ampGainX100);
        for (int c = 0; c < 8; c++) begin
            @(posedge mclk) lraMode <= c[0];
            wr(8'h23, {c[0], c[2:0], c[1:0], c[1:0]});
            rd(8'h23, {c[0], c[2:0], c[1:0], c[1:0]});
            chk("brakeRatio", ratio[c], loopCtrl.brakeRatio);
            chk("brakeFbEnable", c != 7, loopCtrl.brakeFbEnable);
            chk("loopGain", c[1:0], loopCtrl.loopGain);
            chk("backEmfAmpGain", c[1:0], loopCtrl.backEmfAmpGain);
            chk("ampGainX100", amp[{c[0], c[1:0]}], loopCtrl.ampGainX100);
            gateExp = (mags[c] * 8'h64 >= (c[0] ? 8 : 4) * 8'hff) ? mags[c] : 8'h00;
            @(posedge mclk) driveMag <= mags[c];
            @(posedge mclk) #1 chk("gatedMag", gateExp, gatedMag);
        end
        wr(8'h24, 8'h00);
        rd(8'h24, 8'h00);
        rd(8'h23, 8'hff);
        @(posedge mclk) {calGainWrEn, calGainValue} <= 3'b101;
        @(posedge mclk) calGainWrEn <= 1'b0;
        rd(8'h23, 8'hfd);
        chk("backEmfAmpGain", 1, loopCtrl.backEmfAmpGain);
        @(posedge mclk) {calGainWrEn, calGainValue} <= 3'b110;
        wr(8'h23, 8'h00);
        calGainWrEn <= 1'b0;
        rd(8'h23, 8'h00);
        end_of_test;
    end
endmodule // feedback_loop_control_reg_tb_top
`default_nettype wire
